// file: ccbt_params.svh
`ifndef CCBT_PARAMS_SVH
`define CCBT_PARAMS_SVH
// ============================================================
// register offsets (byte addresses)
`define CCBT_OFS_CTRL 8'h00
`define CCBT_OFS_BUSCFG 8'h04
`define CCBT_OFS_STATUS 8'h08
`define CCBT_OFS_MEAS 8'h0C
// ============================================================
// field positions
`define CCBT_CTRL_START 0
`define CCBT_CTRL_WRITE 1
`define CCBT_CFG_WAIT_LSB 0
`define CCBT_CFG_WAIT_MSB 3
`define CCBT_CFG_TRI 4
`define CCBT_CFG_ALEEXT 5
`define CCBT_CFG_RWDLY 6
`define CCBT_ST_DONE 3
// ============================================================
// reset values
`define CCBT_RST_WAIT 4'hF
`define CCBT_RST_TRI 1'h1
`define CCBT_RST_ALEEXT 1'h0
`define CCBT_RST_RWDLY 1'h0
`define CCBT_HALF_INIT 12'h004
// ============================================================
// timing constants: half-period counts, wait and tristate field tops, and the span shift
`define CCBT_BASE_HP 7'h06
`define CCBT_WAIT_TOP 7'h0F
`define CCBT_TRI_TOP 7'h01
`define CCBT_STRB_DLY_HP 7'h02
`define CCBT_STRB_NODLY_HP 7'h03
`define CCBT_RECOV_HP 7'h02
`define CCBT_SPAN_SHIFT 4
`endif

// file: ccbt_pkg.sv
package ccbt_pkg;
  // bus configuration word, latched at the start of every cycle
  typedef struct packed {
    logic rwDelay;
    logic aleExt;
    logic tristate;
    logic [3:0] waitField;
  } ccbt_buscfg_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ALEHI,
    ST_EXT,
    ST_GAP,
    ST_STROBE,
    ST_RECOV
  } ccbt_state_e;
endpackage : ccbt_pkg

// file: ccbt_half_gen.sv
`timescale 1ns/1ps
`include "ccbt_params.svh"
module ccbt_half_gen import ccbt_pkg::*; #(
  parameter int CNT_W = 12
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic pllMode,
  input wire logic xtalIn,
  output logic halfTick,
  output logic cpuClk,
  output logic [CNT_W-1:0] halfLen,
  output logic [CNT_W-1:0] spanLen
);
  logic xtalPrev_reg;
  logic cpuClk_reg;
  logic [CNT_W-1:0] halfCnt_reg;
  logic [CNT_W-1:0] halfLen_reg;
  logic [CNT_W-1:0] spanCnt_reg;
  logic [CNT_W-1:0] spanLen_reg;
  logic [1:0] edgeCnt_reg;
  logic [CNT_W-1:0] halfLen_next;
  logic [CNT_W-1:0] target;
  logic [CNT_W-1:0] spanNow;

  // ============================================================
  // edge and boundary decode
  wire xtalEdge = xtalIn != xtalPrev_reg;
  wire realign = pllMode && xtalEdge && edgeCnt_reg == 2'h3;
  wire hpEnd = pllMode && (halfCnt_reg >= halfLen_reg - CNT_W'(1));
  assign halfTick = pllMode ? (realign || hpEnd) : xtalEdge;
  assign spanNow = spanCnt_reg + CNT_W'(1);
  // span of four transitions holds sixteen half-periods
  assign target = (spanNow >> `CCBT_SPAN_SHIFT) == '0 ? CNT_W'(1) : spanNow >> `CCBT_SPAN_SHIFT;

  // step by one
  // a single count per realign keeps the clock from jumping in frequency
  assign halfLen_next = !realign ? halfLen_reg :
                        (halfLen_reg < target) ? halfLen_reg + CNT_W'(1) :
                        (halfLen_reg > target && halfLen_reg > CNT_W'(1)) ?
                        halfLen_reg - CNT_W'(1) : halfLen_reg;

  // ============================================================
  // input clock tracking
  always_ff @(posedge clk_sys) begin
    // tracked through reset too, so no false edge follows the release
    xtalPrev_reg <= xtalIn;
    if (rst) begin
      edgeCnt_reg <= 2'h0;
      spanCnt_reg <= '0;
      spanLen_reg <= '0;
    end else begin
      if (xtalEdge) edgeCnt_reg <= edgeCnt_reg + 2'h1;
      if (realign) begin
        spanCnt_reg <= '0;
        spanLen_reg <= spanNow;
      end else if (spanCnt_reg != '1) begin
        spanCnt_reg <= spanNow;
      end
    end
  end

  // ============================================================
  // cpu clock generation
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cpuClk_reg <= 1'h0;
      halfCnt_reg <= '0;
      halfLen_reg <= `CCBT_HALF_INIT;
    end else begin
      halfLen_reg <= halfLen_next;
      if (!pllMode) begin
        cpuClk_reg <= xtalIn;
        halfCnt_reg <= '0;
      end else if (realign) begin
        cpuClk_reg <= 1'h1;
        halfCnt_reg <= '0;
      end else if (hpEnd) begin
        cpuClk_reg <= !cpuClk_reg;
        halfCnt_reg <= '0;
      end else begin
        halfCnt_reg <= halfCnt_reg + CNT_W'(1);
      end
    end
  end

  assign cpuClk = cpuClk_reg;
  assign halfLen = halfLen_reg;
  assign spanLen = spanLen_reg;

  // ============================================================
  // checks
  AST_DIRECT_FOLLOW: assert property (@(posedge clk_sys) disable iff (rst)
    !pllMode && !$past(pllMode) |=> cpuClk == $past(xtalIn))
    else $error("direct mode clock does not follow input");
  AST_DIRECT_TICK: assert property (@(posedge clk_sys) disable iff (rst)
    !pllMode |-> (halfTick == (xtalIn != $past(xtalIn))))
    else $error("direct half-period not tied to input edge");
  AST_PLL_SMOOTH: assert property (@(posedge clk_sys) disable iff (rst)
    halfLen_reg != $past(halfLen_reg) |-> $past(realign) &&
    (halfLen_reg == $past(halfLen_reg) + CNT_W'(1) || halfLen_reg == $past(halfLen_reg) - CNT_W'(1)))
    else $error("pll half length stepped abruptly");
  AST_PLL_REALIGN: assert property (@(posedge clk_sys) disable iff (rst)
    realign |=> cpuClk && halfCnt_reg == '0)
    else $error("pll clock not realigned to input");
  AST_PLL_ODD: assert property (@(posedge clk_sys) disable iff (rst)
    pllMode && hpEnd && !realign |=> cpuClk != $past(cpuClk))
    else $error("pll half-period end without clock toggle");
endmodule : ccbt_half_gen

// file: ccbt_top.sv
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "ccbt_params.svh"
module ccbt_top import ccbt_pkg::*; #(
  parameter int CNT_W = 12
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clockModeStrap,
  input wire logic xtalIn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic cpuClk,
  output logic pllEnable,
  output logic busAle,
  output logic busRdWrStrobe,
  output logic busWriteCycle,
  output logic busAddrOe,
  output logic busCycleDone
);
  logic pllMode_reg;
  ccbt_buscfg_s cfg_reg;
  ccbt_buscfg_s cyc_reg;
  ccbt_state_e state_reg;
  ccbt_state_e state_next;
  logic [5:0] phCnt_reg;
  logic [5:0] phCnt_next;
  logic [6:0] hpCnt_reg;
  logic startPend_reg;
  logic writeReq_reg;
  logic doneFlag_reg;
  logic [7:0] cycCount_reg;
  logic [31:0] prdata_reg;
  logic ale_reg;
  logic strobe_reg;
  logic addrOe_reg;
  logic write_reg;
  logic done_reg;
  logic halfTick;
  logic [CNT_W-1:0] halfLen;
  logic [CNT_W-1:0] spanLen;

  // ============================================================
  // half-period source
  ccbt_half_gen #(.CNT_W(CNT_W)) u_half (
    .clk_sys(clk_sys),
    .rst(rst),
    .pllMode(pllMode_reg),
    .xtalIn(xtalIn),
    .halfTick(halfTick),
    .cpuClk(cpuClk),
    .halfLen(halfLen),
    .spanLen(spanLen)
  );

  // ============================================================
  // clock mode strap
  // latch at reset
  // sampled on every edge while reset is held, frozen from release onward
  always_ff @(posedge clk_sys) begin
    if (rst) pllMode_reg <= clockModeStrap;
  end
  assign pllEnable = pllMode_reg;

  // ============================================================
  // APB decode
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire hitCtrl = paddr == `CCBT_OFS_CTRL;
  wire hitCfg = paddr == `CCBT_OFS_BUSCFG;
  wire hitStat = paddr == `CCBT_OFS_STATUS;
  wire hitMeas = paddr == `CCBT_OFS_MEAS;
  wire hit = hitCtrl || hitCfg || hitStat || hitMeas;
  wire wrEn = access && pwrite && hit;
  wire startWr = wrEn && hitCtrl && pwdata[`CCBT_CTRL_START];
  wire doneClr = wrEn && hitStat && pwdata[`CCBT_ST_DONE];
  wire busy = state_reg != ST_IDLE;
  wire [31:0] statWord = {16'h0000, cycCount_reg, 4'h0, doneFlag_reg, cpuClk, pllMode_reg, busy};
  wire [31:0] measWord = {{(16 - CNT_W){1'b0}}, spanLen, {(16 - CNT_W){1'b0}}, halfLen};
  wire [31:0] rdMux = hitCtrl ? {30'h0, writeReq_reg, startPend_reg} :
                      hitCfg ? {25'h0, cfg_reg} :
                      hitStat ? statWord :
                      hitMeas ? measWord : 32'h0000_0000;
  // zero wait states: read data is registered during the setup cycle
  assign pready = access;
  assign pslverr = access && !hit;
  assign prdata = prdata_reg;

  // ============================================================
  // software registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_reg <= '{rwDelay: `CCBT_RST_RWDLY, aleExt: `CCBT_RST_ALEEXT,
                   tristate: `CCBT_RST_TRI, waitField: `CCBT_RST_WAIT};
      writeReq_reg <= 1'h0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      if (wrEn && hitCfg) cfg_reg <= pwdata[6:0];
      if (startWr) writeReq_reg <= pwdata[`CCBT_CTRL_WRITE];
      if (setup) prdata_reg <= rdMux;
    end
  end

  // start request and done flag: the set (software start, hardware done) wins over the clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      startPend_reg <= 1'h0;
      doneFlag_reg <= 1'h0;
      cycCount_reg <= 8'h00;
    end else begin
      if (startWr) startPend_reg <= 1'h1;
      else if (state_reg == ST_IDLE && halfTick) startPend_reg <= 1'h0;
      if (done_reg) doneFlag_reg <= 1'h1;
      else if (doneClr) doneFlag_reg <= 1'h0;
      if (done_reg) cycCount_reg <= cycCount_reg + 8'h01;
    end
  end

  // ============================================================
  // phase lengths in half-periods, loaded into the phase counter minus one
  // stretch terms
  wire [6:0] extHp = {6'h00, cyc_reg.aleExt};
  wire [6:0] waitHp = (`CCBT_WAIT_TOP - {3'h0, cyc_reg.waitField}) << 1;
  wire [6:0] triHp = (`CCBT_TRI_TOP - {6'h00, cyc_reg.tristate}) << 1;
  wire [6:0] dlyHp = {6'h00, cyc_reg.rwDelay};
  wire [6:0] strbHp = (cyc_reg.rwDelay ? `CCBT_STRB_DLY_HP : `CCBT_STRB_NODLY_HP) + waitHp;
  wire [6:0] recHp = `CCBT_RECOV_HP + triHp;
  wire [6:0] totalHp = `CCBT_BASE_HP + (extHp << 1) + waitHp + triHp;
  wire phEnd = halfTick && phCnt_reg == 6'h00;

  // ============================================================
  // bus cycle sequencer
  always_comb begin
    state_next = state_reg;
    phCnt_next = phCnt_reg;
    if (halfTick) phCnt_next = phCnt_reg - 6'h01;
    unique case (state_reg)
      ST_IDLE: begin
        phCnt_next = 6'h00;
        if (halfTick && startPend_reg) begin
          state_next = ST_ALEHI;
          phCnt_next = {5'h00, cfg_reg.aleExt};
        end
      end
      ST_ALEHI: begin
        if (phEnd && cyc_reg.aleExt) begin
          state_next = ST_EXT;
          phCnt_next = extHp[5:0] - 6'h01;
        end else if (phEnd && cyc_reg.rwDelay) begin
          state_next = ST_GAP;
          phCnt_next = 6'h00;
        end else if (phEnd) begin
          state_next = ST_STROBE;
          phCnt_next = strbHp[5:0] - 6'h01;
        end
      end
      ST_EXT: begin
        if (phEnd && cyc_reg.rwDelay) begin
          state_next = ST_GAP;
          phCnt_next = 6'h00;
        end else if (phEnd) begin
          state_next = ST_STROBE;
          phCnt_next = strbHp[5:0] - 6'h01;
        end
      end
      ST_GAP: begin
        if (phEnd) begin
          state_next = ST_STROBE;
          phCnt_next = strbHp[5:0] - 6'h01;
        end
      end
      ST_STROBE: begin
        if (phEnd) begin
          state_next = ST_RECOV;
          phCnt_next = recHp[5:0] - 6'h01;
        end
      end
      ST_RECOV: begin
        if (phEnd) state_next = ST_IDLE;
      end
    endcase
  end

  // address release
  // without delay the address overlaps the first strobe half-period
  wire firstStrobe = state_next == ST_STROBE && phCnt_next == strbHp[5:0] - 6'h01;
  wire addrNext = state_next == ST_ALEHI || state_next == ST_EXT || state_next == ST_GAP ||
                  (firstStrobe && !cyc_reg.rwDelay);

  // state, configuration snapshot and pin levels
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      phCnt_reg <= 6'h00;
      cyc_reg <= '0;
      ale_reg <= 1'h0;
      strobe_reg <= 1'h0;
      addrOe_reg <= 1'h0;
      write_reg <= 1'h0;
      done_reg <= 1'h0;
    end else begin
      state_reg <= state_next;
      phCnt_reg <= phCnt_next;
      if (state_reg == ST_IDLE && halfTick && startPend_reg) begin
        cyc_reg <= cfg_reg;
        write_reg <= writeReq_reg;
      end
      ale_reg <= state_next == ST_ALEHI;
      strobe_reg <= state_next == ST_STROBE;
      addrOe_reg <= addrNext;
      done_reg <= state_reg == ST_RECOV && phEnd;
    end
  end

  // half-periods elapsed in the current cycle, for the phase checks
  always_ff @(posedge clk_sys) begin
    if (rst || state_reg == ST_IDLE) hpCnt_reg <= 7'h00;
    else if (halfTick) hpCnt_reg <= hpCnt_reg + 7'h01;
  end

  assign busAle = ale_reg;
  assign busRdWrStrobe = strobe_reg;
  assign busAddrOe = addrOe_reg;
  assign busWriteCycle = write_reg;
  assign busCycleDone = done_reg;

  // ============================================================
  // checks
  // hpCnt_reg counts half-period ticks from the latch rise, zero while idle,
  // so every phase check below is a count of ticks at the edge it names
  // the first edge after a release is skipped: the strap is still being caught there
  AST_MODE_HELD: assert property (@(posedge clk_sys) disable iff (rst)
    !$past(rst) |-> $stable(pllMode_reg))
    else $error("clock mode changed outside reset");
  AST_ALE_HIGH: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(ale_reg) |-> hpCnt_reg == 7'h01 + extHp)
    else $error("latch strobe high time wrong");
  AST_STRB_START: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(strobe_reg) |-> hpCnt_reg == 7'h01 + (extHp << 1) + dlyHp && !ale_reg)
    else $error("strobe start misplaced after latch fall");
  AST_STRB_LEN: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(strobe_reg) |-> hpCnt_reg == 7'h01 + (extHp << 1) + dlyHp + strbHp)
    else $error("strobe length wrong");
  AST_ADDR_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(addrOe_reg) |-> hpCnt_reg == 7'h02 + (extHp << 1))
    else $error("address hold after latch fall wrong");
  AST_ADDR_SETUP: assert property (@(posedge clk_sys) disable iff (rst)
    ale_reg |-> addrOe_reg && (!$rose(ale_reg) || $rose(addrOe_reg)))
    else $error("address not driven around latch strobe");
  AST_CYCLE_LEN: assert property (@(posedge clk_sys) disable iff (rst)
    state_reg == ST_RECOV && phEnd |=> done_reg && hpCnt_reg == totalHp)
    else $error("bus cycle length wrong");
  AST_ADDR_RELEASE: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(strobe_reg) |-> addrOe_reg == !cyc_reg.rwDelay)
    else $error("address release against strobe start wrong");
  AST_STRB_NO_ALE: assert property (@(posedge clk_sys) disable iff (rst)
    strobe_reg |-> !ale_reg && !done_reg)
    else $error("strobe overlaps latch strobe or cycle end");
  AST_DONE_PULSE: assert property (@(posedge clk_sys) disable iff (rst)
    done_reg |=> !done_reg)
    else $error("cycle done pulse longer than one clock");
  AST_IDLE_QUIET: assert property (@(posedge clk_sys) disable iff (rst)
    state_reg == ST_IDLE |-> !ale_reg && !strobe_reg && !addrOe_reg)
    else $error("bus pins active while idle");
  // scenarios worth seeing at least once
  COV_PLL_CYCLE: cover property (@(posedge clk_sys) disable iff (rst)
    pllMode_reg && done_reg);
  COV_DELAY_CYCLE: cover property (@(posedge clk_sys) disable iff (rst)
    done_reg && cyc_reg.rwDelay && cyc_reg.aleExt);
  COV_WAIT_CYCLE: cover property (@(posedge clk_sys) disable iff (rst)
    done_reg && cyc_reg.waitField == 4'h0 && !cyc_reg.tristate);
  COV_DIRECT_CYCLE: cover property (@(posedge clk_sys) disable iff (rst)
    !pllMode_reg && done_reg);
  COV_EXT_NODELAY: cover property (@(posedge clk_sys) disable iff (rst)
    done_reg && cyc_reg.aleExt && !cyc_reg.rwDelay);
endmodule : ccbt_top

// file: ccbt_bus_dev.sv
`timescale 1ns/1ps
// ============================================================
// bus-side device model
// it only listens, so widths are kept in clk_sys cycles; the bench scales its expected widths to match
module ccbt_bus_dev (
  input wire logic clk_sys,
  input wire logic busAle,
  input wire logic busRdWrStrobe,
  input wire logic busAddrOe,
  input wire logic busCycleDone,
  output int aleW,
  output int strbW,
  output int oeW,
  output int gapW,
  output int perW,
  output int doneCnt,
  output logic noAddr
);
  int aC = 0;
  int sC = 0;
  int oC = 0;
  int gC = 0;
  int pC = 0;
  logic aQ = 1'b0;
  logic sQ = 1'b0;
  logic oQ = 1'b0;
  logic noAddrQ = 1'b0;
  // widths start at the int default of zero; only the flag needs a start value
  assign noAddr = noAddrQ;
  // width counters, stored on each falling edge; gap on the strobe rise, period on the latch rise
  always @(posedge clk_sys) begin
    aQ <= busAle;
    sQ <= busRdWrStrobe;
    oQ <= busAddrOe;
    aC <= busAle ? aC + 1 : 0;
    sC <= busRdWrStrobe ? sC + 1 : 0;
    oC <= busAddrOe ? oC + 1 : 0;
    gC <= (aQ && !busAle) ? 0 : gC + 1;
    pC <= (busAle && !aQ) ? 1 : pC + 1;
    doneCnt <= doneCnt + int'(busCycleDone);
    if (aQ && !busAle)
      aleW <= aC;
    if (sQ && !busRdWrStrobe)
      strbW <= sC;
    if (oQ && !busAddrOe)
      oeW <= oC;
    if (busRdWrStrobe && !sQ)
      gapW <= (aQ && !busAle) ? 0 : gC + 1;
    if (busAle && !aQ)
      perW <= pC;
    if (busAle && !busAddrOe)
      noAddrQ <= 1'b1;
  end
endmodule : ccbt_bus_dev

// file: ccbt_top_tb.sv
`timescale 1ns/1ps
module ccbt_top_tb import ccbt_pkg::*;;
  // ============================================================
  // signals
  logic clk_sys = 0, rst = 1, clockModeStrap = 0, xtalIn = 0, psel = 0, penable = 0;
  logic pwrite = 0, pready, pslverr, cpuClk, pllEnable, busAle, busRdWrStrobe;
  logic busWriteCycle, busAddrOe, busCycleDone, noAddr, erv, xq;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdv, lfsrState = 32'hDCED;
  int errors = 0, checks = 0, xHi = 4, xLo = 4, xc = 0;
  int aleW, strbW, oeW, gapW, perW, doneCnt, i, k, n, h, prev;
  ccbt_buscfg_s cfg;
  ccbt_top ccbt_top_inst (.clk_sys(clk_sys), .rst(rst), .clockModeStrap(clockModeStrap),
    .xtalIn(xtalIn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpuClk(cpuClk),
    .pllEnable(pllEnable), .busAle(busAle), .busRdWrStrobe(busRdWrStrobe),
    .busWriteCycle(busWriteCycle), .busAddrOe(busAddrOe), .busCycleDone(busCycleDone));
  ccbt_bus_dev ccbt_bus_dev_inst (.clk_sys(clk_sys), .busAle(busAle),
    .busRdWrStrobe(busRdWrStrobe), .busAddrOe(busAddrOe), .busCycleDone(busCycleDone),
    .aleW(aleW), .strbW(strbW), .oeW(oeW), .gapW(gapW), .perW(perW), .doneCnt(doneCnt),
    .noAddr(noAddr));
  // 125 MHz system clock
  initial forever #4 clk_sys = ~clk_sys;
  // input oscillator with programmable high and low phases
  always @(posedge clk_sys) begin
    xc <= xc + 1;
    if (xc + 1 >= (xtalIn ? xHi : xLo)) begin
      xtalIn <= ~xtalIn;
      xc <= 0;
    end
  end
  // ============================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // expected widths in clk_sys cycles, four per half-period
  function automatic logic [31:0] expW(input int sel, input ccbt_buscfg_s c);
    int e, d, w, t;
    e = int'(c.aleExt);
    d = int'(c.rwDelay);
    w = 15 - int'(c.waitField);
    t = 1 - int'(c.tristate);
    case (sel)
      0: return 4 * (1 + e);
      1: return 4 * ((d != 0 ? 2 : 3) + 2 * w);
      2: return 4 * (2 + 2 * e);
      3: return 4 * (e + d);
      // a pending start waits for the next tick, so back-to-back latch rises
      // sit one idle half-period further apart than the cycle itself
      default: return 4 * (7 + 2 * e + 2 * w + 2 * t);
    endcase
  endfunction : expW
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  task automatic results;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  // one APB transfer; an idle cycle after it keeps drivers single per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int m;
    m = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      m++;
      if (m > 50) begin
        errors++;
        results();
      end
      @(posedge clk_sys);
    end
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic waitDone(input int tgt);
    int m;
    m = 0;
    while (doneCnt < tgt) begin
      m++;
      if (m > 2000) begin
        errors++;
        results();
      end
      @(posedge clk_sys);
    end
  endtask : waitDone
  // ============================================================
  // main sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    xHi <= 2 + int'(lfsrState[1:0]);
    xLo <= 3 + int'(lfsrState[3:2]);
    @(posedge clk_sys);
    clockModeStrap <= 1'b1;
    // step off the edge so the first sample of the input clock is settled
    #1;
    for (i = 0; i < 200; i++) begin
      xq = xtalIn;
      @(posedge clk_sys);
      #1 chk("cpu clock", {31'h0, xq}, {31'h0, cpuClk});
    end
    @(posedge clk_sys);
    xHi <= 4;
    xLo <= 4;
    chk("direct mode", 32'h0, {31'h0, pllEnable});
    apb(1'b0, 8'h04, 32'h0);
    chk("buscfg reset", 32'h0000001F, rdv);
    apb(1'b1, 8'h10, 32'hFFFFFFFF);
    chk("unmapped", 32'h1, {31'h0, erv});
    for (k = 0; k < 10; k++) begin
      lfsrState = lfsr(lfsrState);
      cfg = (k == 0) ? 7'h1F : (k == 1) ? 7'h60 : lfsrState[6:0];
      apb(1'b1, 8'h04, {25'h0, cfg});
      apb(1'b0, 8'h04, 32'h0);
      chk("buscfg", {25'h0, cfg}, rdv);
      n = doneCnt + 2;
      apb(1'b1, 8'h00, {30'h0, lfsrState[9], 1'b1});
      h = 0;
      while (busAle !== 1'b1 && h < 200) begin
        h++;
        @(posedge clk_sys);
      end
      chk("ale rise", 32'h1, {31'h0, busAle});
      // second start lands while busy, so the two cycles run back to back
      apb(1'b1, 8'h00, {30'h0, lfsrState[9], 1'b1});
      waitDone(n);
      chk("write flag", {31'h0, lfsrState[9]}, {31'h0, busWriteCycle});
      chk("ale width", expW(0, cfg), aleW);
      chk("strobe width", expW(1, cfg), strbW);
      chk("addr width", expW(2, cfg), oeW);
      chk("strobe gap", expW(3, cfg), gapW);
      chk("cycle period", expW(4, cfg), perW);
    end
    chk("addr at ale", 32'h0, {31'h0, noAddr});
    apb(1'b0, 8'h08, 32'h0);
    chk("done sticky", 32'h1, {31'h0, rdv[3]});
    apb(1'b1, 8'h08, 32'h00000008);
    apb(1'b0, 8'h08, 32'h0);
    chk("done clear", 32'h0, {31'h0, rdv[3]});
    // second reset into the multiplied mode
    rst <= 1'b1;
    xHi <= 8;
    xLo <= 8;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    clockModeStrap <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk("pll mode", 32'h1, {31'h0, pllEnable});
    prev = 4;
    for (i = 0; i < 120; i++) begin
      apb(1'b0, 8'h0C, 32'h0);
      n = int'(rdv[11:0]) - prev;
      chk("pll step", 32'h1, {31'h0, n >= -1 && n <= 1});
      prev = int'(rdv[11:0]);
    end
    chk("pll half", 32'h2, {20'h0, rdv[11:0]});
    chk("pll span", 32'h20, {20'h0, rdv[27:16]});
    // one bus cycle on the multiplied clock with the reset configuration
    cfg = 7'h1F;
    n = doneCnt + 1;
    apb(1'b1, 8'h00, 32'h00000001);
    waitDone(n);
    chk("pll strobe", expW(1, cfg) / 2, strbW);
    n = 0;
    #1;
    for (i = 0; i < 64; i++) begin
      xq = cpuClk;
      @(posedge clk_sys);
      #1;
      if (cpuClk === 1'b1 && xq === 1'b0)
        n++;
    end
    chk("pll ratio", 32'h1, {31'h0, n >= 15 && n <= 17});
    results();
  end
endmodule : ccbt_top_tb
